/* design/divpulse_consts.svh */
// Constants for the encoder divided pulse output block.
`ifndef DIVPULSE_CONSTS_SVH
`define DIVPULSE_CONSTS_SVH
// Register offsets on the plain register port (byte addresses).
`define OFS_CONFIG 8'h00
`define OFS_PULSES_PER_REV 8'h04
`define OFS_LINEAR_RES 8'h08
`define OFS_ROTARY_MAX_SPEED 8'h0c
`define OFS_LINEAR_MAX_SPEED 8'h10
`define OFS_STATUS 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_RESTART 8'h20
// Config field positions.
`define CFG_LINEAR_BIT 0
`define CFG_ORIGIN_BOTH_BIT 1
`define CFG_DIR_REVERSE_BIT 2
`define CFG_SCALE_COUNT_DIR_BIT 3
// Interrupt status bit positions.
`define IRQ_OVERSPEED_BIT 0
`define IRQ_SETTING_ERR_BIT 1
`define IRQ_ORIGIN_BIT 2
// Reset values of the settings.
`define RST_PULSES_PER_REV 32'd2048
`define RST_LINEAR_RES 32'd20
`define RST_ROTARY_MAX_SPEED 16'd10000
`define RST_LINEAR_MAX_SPEED 16'd50
// Limits of the settings.
`define MIN_PULSES_PER_REV 32'd16
`define MAX_PULSES_PER_REV 32'd4194304
`define MAX_LINEAR_RES 32'd4096
`define MIN_LINEAR_RES 32'd1
`define LINEAR_SPEED_STEP_MMPS 16'd100
`endif

/* design/divpulse_pkg.sv */
// Types shared by the encoder divided pulse output block.
package divpulse_pkg;
  // Settings that take effect only at restart.
  typedef struct packed {
    logic linear;
    logic origin_both;
    logic dir_reverse;
    logic scale_count_up_fwd;
    logic [31:0] pulses_per_rev;
    logic [31:0] linear_res;
    logic [15:0] rotary_max_speed;
    logic [15:0] linear_max_speed;
  } settings_type;
  // One encoder sample carried into the block.
  typedef struct packed {
    logic valid;
    logic signed [15:0] delta;
    logic origin_mark;
  } enc_sample_type;
  // Quadrature output pins.
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic origin;
  } quad_pins_type;
endpackage : divpulse_pkg

/* design/quad_step_gen.sv */
// Quadrature step sequencer: turns step requests into A/B edges.
`timescale 1ns/100ps
module quad_step_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Step request
  input wire logic step,
  input wire logic step_fwd,
  // Outputs
  output logic phase_a,
  output logic phase_b,
  output logic a_rise
);
  logic [1:0] state_reg;
  logic [1:0] state_next;

  // Count 0..3 maps to {a,b} 00,10,11,01, so A leads B when stepping forward.
  always_comb begin
    state_next = state_reg;
    if (step) begin
      state_next = step_fwd ? state_reg + 2'h1 : state_reg - 2'h1;
    end
  end

  // Step state register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Phase outputs decoded from the count into gray code.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_a <= 1'b0;
      phase_b <= 1'b0;
      a_rise <= 1'b0;
    end else begin
      phase_a <= state_next[1] ^ state_next[0];
      phase_b <= state_next[1];
      a_rise <= step && !phase_a && (state_next[1] ^ state_next[0]);
    end
  end
endmodule : quad_step_gen

/* design/speed_monitor.sv */
// Speed monitor: measures encoder counts per window and flags overspeed.
`timescale 1ns/100ps
module speed_monitor #(
  parameter int WINDOW_CYCLES = 250000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Encoder movement
  input wire logic sample_valid,
  input wire logic [15:0] sample_mag,
  // Limit in encoder counts per window
  input wire logic [31:0] limit_counts,
  // Result
  output logic overspeed,
  output logic [31:0] last_counts
);
  logic [31:0] win_reg;
  logic [31:0] acc_reg;

  // Window timer.
  always_ff @(posedge clk_sys) begin
    if (rst || win_reg == 32'(WINDOW_CYCLES - 1)) begin
      win_reg <= 32'h0;
    end else begin
      win_reg <= win_reg + 32'h1;
    end
  end

  // Count accumulation; result captured at the end of each window.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc_reg <= 32'h0;
      last_counts <= 32'h0;
      overspeed <= 1'b0;
    end else if (win_reg == 32'(WINDOW_CYCLES - 1)) begin
      acc_reg <= 32'h0;
      last_counts <= acc_reg;
      overspeed <= acc_reg > limit_counts;
    end else begin
      overspeed <= 1'b0;
      if (sample_valid) begin
        acc_reg <= acc_reg + {16'h0, sample_mag};
      end
    end
  end
endmodule : speed_monitor

/* design/divided_pulse_out.sv */
// Encoder divided pulse output with origin pulse, speed limit and registers.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "divpulse_consts.svh"
module divided_pulse_out #(
  parameter int ENC_COUNTS_PER_REV = 16777216,
  parameter int SPEED_WINDOW_CYCLES = 250000,
  parameter int SCALE_PITCH_COUNTS = 4096,
  parameter int LINEAR_RES_BASE_SPEED = 50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Encoder samples
  input wire divpulse_pkg::enc_sample_type enc_in,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Pulse outputs
  output logic quad_phase_a_out,
  output logic quad_phase_a_out_n,
  output logic quad_phase_b_out,
  output logic quad_phase_b_out_n,
  output logic origin_pulse_out,
  output logic origin_pulse_out_n,
  // Alarms and interrupt
  output logic overspeed_alarm,
  output logic setting_error_alarm,
  output logic irq
);
  divpulse_pkg::settings_type staged_reg;
  divpulse_pkg::settings_type active_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [31:0] divisor;
  logic [31:0] step_size;
  logic [47:0] phase_acc_reg;
  logic step;
  logic step_fwd;
  logic phase_a;
  logic phase_b;
  logic a_rise;
  logic overspeed;
  logic [31:0] last_counts;
  logic [31:0] limit_counts;
  logic [15:0] sample_mag;
  logic origin_armed_reg;
  logic origin_pending_reg;
  logic origin_active_reg;
  logic origin_start;
  logic origin_on;
  logic setting_err;
  logic restart_req;
  logic [31:0] res_limit;

  // Required setting increment for a rotary pulse count.
  function automatic logic [31:0] pulse_increment(input logic [31:0] cnt);
    logic [31:0] inc;
    inc = 32'h1;
    for (int i = 0; i < 8; i++) begin
      if (cnt > (32'h4000 << i)) begin
        inc = 32'h2 << i;
      end
    end
    return inc;
  endfunction : pulse_increment

  assign restart_req = reg_write && reg_addr == `OFS_RESTART && reg_wdata[0];

  // Staged settings written by software.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      staged_reg.linear <= 1'b0;
      staged_reg.origin_both <= 1'b0;
      staged_reg.dir_reverse <= 1'b0;
      staged_reg.scale_count_up_fwd <= 1'b1;
      staged_reg.pulses_per_rev <= `RST_PULSES_PER_REV;
      staged_reg.linear_res <= `RST_LINEAR_RES;
      staged_reg.rotary_max_speed <= `RST_ROTARY_MAX_SPEED;
      staged_reg.linear_max_speed <= `RST_LINEAR_MAX_SPEED;
    end else if (reg_write) begin
      case (reg_addr)
        `OFS_CONFIG: begin
          staged_reg.linear <= reg_wdata[`CFG_LINEAR_BIT];
          staged_reg.origin_both <= reg_wdata[`CFG_ORIGIN_BOTH_BIT];
          staged_reg.dir_reverse <= reg_wdata[`CFG_DIR_REVERSE_BIT];
          staged_reg.scale_count_up_fwd <= reg_wdata[`CFG_SCALE_COUNT_DIR_BIT];
        end
        `OFS_PULSES_PER_REV: staged_reg.pulses_per_rev <= reg_wdata;
        `OFS_LINEAR_RES: staged_reg.linear_res <= reg_wdata;
        `OFS_ROTARY_MAX_SPEED: staged_reg.rotary_max_speed <= reg_wdata[15:0];
        `OFS_LINEAR_MAX_SPEED: staged_reg.linear_max_speed <= reg_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // Active settings are copied from the staged ones only at restart.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_reg.linear <= 1'b0;
      active_reg.origin_both <= 1'b0;
      active_reg.dir_reverse <= 1'b0;
      active_reg.scale_count_up_fwd <= 1'b1;
      active_reg.pulses_per_rev <= `RST_PULSES_PER_REV;
      active_reg.linear_res <= `RST_LINEAR_RES;
      active_reg.rotary_max_speed <= `RST_ROTARY_MAX_SPEED;
      active_reg.linear_max_speed <= `RST_LINEAR_MAX_SPEED;
    end else if (restart_req) begin
      active_reg <= staged_reg;
    end
  end

  // Linear resolution limit grows as the maximum speed is lowered.
  always_comb begin
    res_limit = `MAX_LINEAR_RES;
    if (active_reg.linear_max_speed > 16'(LINEAR_RES_BASE_SPEED)) begin
      res_limit = 32'(`MAX_LINEAR_RES * LINEAR_RES_BASE_SPEED) /
                  {16'h0, active_reg.linear_max_speed};
    end
  end

  // Setting check against increments and encoder resolution.
  always_comb begin
    if (active_reg.linear) begin
      setting_err = active_reg.linear_res < `MIN_LINEAR_RES ||
                    active_reg.linear_res > res_limit ||
                    active_reg.linear_res > 32'(SCALE_PITCH_COUNTS);
    end else begin
      setting_err = active_reg.pulses_per_rev < `MIN_PULSES_PER_REV ||
                    active_reg.pulses_per_rev > `MAX_PULSES_PER_REV ||
                    active_reg.pulses_per_rev > 32'(ENC_COUNTS_PER_REV) ||
                    (active_reg.pulses_per_rev &
                     (pulse_increment(active_reg.pulses_per_rev) - 32'h1)) != 32'h0;
    end
  end

  // Phase accumulator: edges per revolution or per pitch set the step size.
  always_comb begin
    divisor = active_reg.linear ? 32'(SCALE_PITCH_COUNTS) : 32'(ENC_COUNTS_PER_REV);
    step_size = active_reg.linear ? active_reg.linear_res
                                  : {active_reg.pulses_per_rev[29:0], 2'b00};
    sample_mag = enc_in.delta[15] ? 16'(-enc_in.delta) : enc_in.delta;
  end

  // Accumulate scaled movement and emit one quadrature step per wrap.
  always_ff @(posedge clk_sys) begin
    if (rst || restart_req) begin
      phase_acc_reg <= 48'h0;
      step <= 1'b0;
      step_fwd <= 1'b1;
    end else begin
      step <= 1'b0;
      if (enc_in.valid && !setting_err) begin
        // Direction reversal is applied upstream on the count, so the
        // A/B/C relation stays the same in either setting.
        step_fwd <= !enc_in.delta[15];
        if (48'(phase_acc_reg + 48'(sample_mag) * 48'(step_size)) >= 48'(divisor)) begin
          phase_acc_reg <= 48'(phase_acc_reg + 48'(sample_mag) * 48'(step_size) -
                               48'(divisor));
          step <= 1'b1;
        end else begin
          phase_acc_reg <= 48'(phase_acc_reg + 48'(sample_mag) * 48'(step_size));
        end
      end
    end
  end

  quad_step_gen u_quad (
    .clk_sys(clk_sys),
    .rst(rst),
    .step(step),
    .step_fwd(step_fwd),
    .phase_a(phase_a),
    .phase_b(phase_b),
    .a_rise(a_rise)
  );

  // Maximum speed in encoder counts per measuring window.
  always_comb begin
    if (active_reg.linear) begin
      limit_counts = 32'({16'h0, active_reg.linear_max_speed} * 32'(SCALE_PITCH_COUNTS));
    end else begin
      limit_counts = 32'((64'(active_reg.rotary_max_speed) * 64'(ENC_COUNTS_PER_REV) *
                     64'(SPEED_WINDOW_CYCLES)) / 64'd15000000000);
    end
  end

  speed_monitor #(
    .WINDOW_CYCLES(SPEED_WINDOW_CYCLES)
  ) u_speed (
    .clk_sys(clk_sys),
    .rst(rst),
    .sample_valid(enc_in.valid),
    .sample_mag(sample_mag),
    .limit_counts(limit_counts),
    .overspeed(overspeed),
    .last_counts(last_counts)
  );

  // Origin gating: armed after the first forward pass, then direction select.
  always_ff @(posedge clk_sys) begin
    if (rst || restart_req) begin
      origin_armed_reg <= 1'b0;
      origin_pending_reg <= 1'b0;
    end else begin
      if (a_rise) begin
        origin_pending_reg <= 1'b0;
      end
      if (enc_in.valid && enc_in.origin_mark) begin
        // Every forward mark crossing is honoured; a reverse one only once armed with origin_both set.
        if (!enc_in.delta[15] ^ (active_reg.linear && !active_reg.scale_count_up_fwd)) begin
          origin_armed_reg <= 1'b1;
          origin_pending_reg <= 1'b1;
        end else if (origin_armed_reg && active_reg.origin_both) begin
          origin_pending_reg <= 1'b1;
        end
      end
    end
  end

  // Origin pulse spans exactly one phase A high period.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      origin_active_reg <= 1'b0;
    end else if (a_rise) begin
      origin_active_reg <= origin_pending_reg;
    end else if (!phase_a) begin
      origin_active_reg <= 1'b0;
    end
  end

  // The pending mark is used at the phase A rise itself, so the pulse starts with A.
  assign origin_start = a_rise && origin_pending_reg;
  assign origin_on = a_rise ? origin_pending_reg : origin_active_reg;

  // Pin drivers with complementary pairs.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      quad_phase_a_out <= 1'b0;
      quad_phase_a_out_n <= 1'b1;
      quad_phase_b_out <= 1'b0;
      quad_phase_b_out_n <= 1'b1;
      origin_pulse_out <= 1'b0;
      origin_pulse_out_n <= 1'b1;
    end else begin
      quad_phase_a_out <= phase_a;
      quad_phase_a_out_n <= !phase_a;
      quad_phase_b_out <= phase_b;
      quad_phase_b_out_n <= !phase_b;
      origin_pulse_out <= origin_on && phase_a;
      origin_pulse_out_n <= !(origin_on && phase_a);
    end
  end

  // Alarm levels.
  always_ff @(posedge clk_sys) begin
    if (rst || restart_req) begin
      overspeed_alarm <= 1'b0;
      setting_error_alarm <= 1'b0;
    end else begin
      if (overspeed) begin
        overspeed_alarm <= 1'b1;
      end
      setting_error_alarm <= setting_err;
    end
  end

  // Sticky interrupt status; a new event wins over a write-one clear.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      if (reg_write && reg_addr == `OFS_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata[2:0];
      end
      irq_status_reg <= (irq_status_reg &
                         ~((reg_write && reg_addr == `OFS_IRQ_STATUS) ? reg_wdata[2:0] : 3'h0))
                        | {origin_start, setting_err, overspeed};
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read data one cycle after the read strobe.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      case (reg_addr)
        `OFS_CONFIG: reg_rdata <= {28'h0, staged_reg.scale_count_up_fwd, staged_reg.dir_reverse,
                                   staged_reg.origin_both, staged_reg.linear};
        `OFS_PULSES_PER_REV: reg_rdata <= staged_reg.pulses_per_rev;
        `OFS_LINEAR_RES: reg_rdata <= staged_reg.linear_res;
        `OFS_ROTARY_MAX_SPEED: reg_rdata <= {16'h0, staged_reg.rotary_max_speed};
        `OFS_LINEAR_MAX_SPEED: reg_rdata <= {16'h0, staged_reg.linear_max_speed};
        `OFS_STATUS: reg_rdata <= {last_counts[27:0], origin_armed_reg, phase_b, phase_a,
                                   setting_error_alarm | overspeed_alarm};
        `OFS_IRQ_STATUS: reg_rdata <= {29'h0, irq_status_reg};
        `OFS_IRQ_MASK: reg_rdata <= {29'h0, irq_mask_reg};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule : divided_pulse_out

/* tb/host_feedback_model.sv */
// Host controller model that counts quadrature feedback and times the origin pulse.
`timescale 1ns/100ps
module host_feedback_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Feedback pins
  input wire logic phase_a,
  input wire logic phase_a_n,
  input wire logic phase_b,
  input wire logic phase_b_n,
  input wire logic origin,
  input wire logic origin_n,
  // Counts seen by the host
  output logic signed [31:0] position,
  output logic [15:0] origin_count,
  output logic [15:0] bad_count,
  output logic [15:0] a_high_len,
  output logic [15:0] c_high_len
);
  logic a_reg;
  logic b_reg;
  logic c_reg;
  logic [15:0] a_run_reg;
  logic [15:0] c_run_reg;

  // Decodes each legal step as one count; a double step or a broken pair is counted as bad.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      position <= 0;
      bad_count <= 16'h0;
    end else if (phase_a_n === phase_a || phase_b_n === phase_b || origin_n === origin) begin
      bad_count <= bad_count + 16'h1;
    end else if ({phase_a, phase_b} != {a_reg, b_reg}) begin
      if (phase_a == !b_reg && phase_b == a_reg) begin
        position <= position + 1;
      end else if (phase_a == b_reg && phase_b == !a_reg) begin
        position <= position - 1;
      end else begin
        bad_count <= bad_count + 16'h1;
      end
    end
  end

  // Times the high periods of phase A and of the origin pulse and counts origin pulses.
  always_ff @(posedge clk_sys) begin
    a_reg <= rst ? 1'b0 : phase_a;
    b_reg <= rst ? 1'b0 : phase_b;
    c_reg <= rst ? 1'b0 : origin;
    a_run_reg <= phase_a ? a_run_reg + 16'h1 : 16'h0;
    c_run_reg <= origin ? c_run_reg + 16'h1 : 16'h0;
    if (a_reg && !phase_a) begin
      a_high_len <= a_run_reg;
    end
    if (c_reg && !origin) begin
      c_high_len <= c_run_reg;
    end
    origin_count <= rst ? 16'h0 : origin_count + 16'(origin && !c_reg);
  end
endmodule : host_feedback_model

/* tb/divided_pulse_out_checker.sv */
// Checker of the pulse pins' order, timing and alarm behaviour.
`timescale 1ns/100ps
module divided_pulse_out_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched inputs
  input wire divpulse_pkg::enc_sample_type enc_in,
  input wire logic reg_write,
  // Watched outputs
  input wire logic quad_phase_a_out,
  input wire logic quad_phase_a_out_n,
  input wire logic quad_phase_b_out,
  input wire logic quad_phase_b_out_n,
  input wire logic origin_pulse_out,
  input wire logic origin_pulse_out_n,
  input wire logic overspeed_alarm,
  input wire logic setting_error_alarm
);
  logic [1:0] ab;

  // Phase pair gathered for the order checks.
  assign ab = {quad_phase_a_out, quad_phase_b_out};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_pairs_inverse: assert property (
    {quad_phase_a_out_n, quad_phase_b_out_n, origin_pulse_out_n} ==
    ~{quad_phase_a_out, quad_phase_b_out, origin_pulse_out}) else $error("Pin pair not inverse");
  a_single_edge: assert property (!(&(ab ^ $past(ab))))
    else $error("A and B moved together");
  a_edge_cause: assert property ($changed(ab) |-> $past(enc_in.valid, 3))
    else $error("Edge without a sample three cycles before");
  a_fwd_order: assert property ($changed(ab) && !$past(enc_in.delta[15], 3)
    |-> ab == {!$past(ab[0]), $past(ab[1])}) else $error("Forward edge out of order");
  a_rev_order: assert property ($changed(ab) && $past(enc_in.delta[15], 3)
    |-> ab == {$past(ab[0]), !$past(ab[1])}) else $error("Reverse edge out of order");
  a_err_freeze: assert property (setting_error_alarm [*3] |-> $stable(ab))
    else $error("Edge during setting error");
  a_speed_sticky: assert property (overspeed_alarm && !reg_write && !$past(reg_write)
    |=> overspeed_alarm) else $error("Overspeed alarm dropped");
  a_origin_start: assert property ($rose(origin_pulse_out) |-> $rose(quad_phase_a_out))
    else $error("Origin pulse not started with phase A");
  a_origin_end: assert property ($fell(origin_pulse_out) |-> $fell(quad_phase_a_out))
    else $error("Origin pulse not ended with phase A");
endmodule : divided_pulse_out_checker

bind divided_pulse_out divided_pulse_out_checker checker_inst (
  .clk_sys(clk_sys), .rst(rst), .enc_in(enc_in), .reg_write(reg_write),
  .quad_phase_a_out(quad_phase_a_out), .quad_phase_a_out_n(quad_phase_a_out_n),
  .quad_phase_b_out(quad_phase_b_out), .quad_phase_b_out_n(quad_phase_b_out_n),
  .origin_pulse_out(origin_pulse_out), .origin_pulse_out_n(origin_pulse_out_n),
  .overspeed_alarm(overspeed_alarm), .setting_error_alarm(setting_error_alarm)
);

/* tb/tb.sv */
// Self-checking testbench of the divided pulse output block.
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("BAD %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb;
  logic clk_sys;
  logic rst;
  divpulse_pkg::enc_sample_type enc_in;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic pa, pa_n, pb, pb_n, pc, pc_n;
  logic overspeed_alarm, setting_error_alarm, irq;
  logic signed [31:0] position;
  logic signed [31:0] pos_hold;
  logic [15:0] origin_count, bad_count, a_len, c_len;
  logic [31:0] rd_val;
  int mismatches;
  int num_checks;

  // Small counts keep one revolution at 64 encoder counts and a speed window at 100 cycles.
  divided_pulse_out #(.ENC_COUNTS_PER_REV(64), .SPEED_WINDOW_CYCLES(100),
    .SCALE_PITCH_COUNTS(16), .LINEAR_RES_BASE_SPEED(50)) dut (
    .clk_sys(clk_sys), .rst(rst), .enc_in(enc_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .quad_phase_a_out(pa), .quad_phase_a_out_n(pa_n), .quad_phase_b_out(pb),
    .quad_phase_b_out_n(pb_n), .origin_pulse_out(pc), .origin_pulse_out_n(pc_n),
    .overspeed_alarm(overspeed_alarm), .setting_error_alarm(setting_error_alarm), .irq(irq));

  host_feedback_model host (
    .clk_sys(clk_sys), .rst(rst), .phase_a(pa), .phase_a_n(pa_n), .phase_b(pb),
    .phase_b_n(pb_n), .origin(pc), .origin_n(pc_n), .position(position),
    .origin_count(origin_count), .bad_count(bad_count), .a_high_len(a_len), .c_high_len(c_len));

  // Free-running 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read strobe is taken.
  task automatic chk_reg(input logic [7:0] addr, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    rd_val = reg_rdata;
    `CHK("register", exp, rd_val)
  endtask : chk_reg

  // One count per sample, four cycles apart; mark_at picks the sample that crosses the mark.
  task automatic move(input int n, input logic neg, input int mark_at);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      enc_in <= '{1'b1, neg ? 16'hffff : 16'h0001, i == mark_at};
      @(posedge clk_sys);
      enc_in <= '0;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : move

  // Waits one full speed window, so the window holding earlier counts has closed.
  task automatic settle();
    repeat (100) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic restart();
    wr(8'h20, 32'h1);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : restart

  task automatic close_out();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    enc_in = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    chk_reg(8'h00, 32'h8);
    chk_reg(8'h04, 32'h800);
    chk_reg(8'h08, 32'h14);
    chk_reg(8'h0c, 32'h2710);
    chk_reg(8'h10, 32'h32);
    chk_reg(8'h18, 32'h2);
    chk_reg(8'h24, 32'h0);
    // Rotary at 16 pulses per revolution; the first mark is crossed in reverse.
    wr(8'h04, 32'h10);
    wr(8'h1c, 32'h4);
    restart();
    move(8, 1'b1, 2);
    `CHK("origin count", 16'h0, origin_count)
    `CHK("position", -8, position)
    `CHK("irq", 1'b0, irq)
    settle();
    `CHK("overspeed", 1'b1, overspeed_alarm)
    move(64, 1'b0, 10);
    `CHK("origin count", 16'h1, origin_count)
    `CHK("origin width", a_len, c_len)
    `CHK("phase a width", 16'h8, a_len)
    `CHK("position", 56, position)
    `CHK("irq", 1'b1, irq)
    settle();
    chk_reg(8'h18, 32'h7);
    wr(8'h18, 32'h7);
    chk_reg(8'h18, 32'h0);
    `CHK("origin status", 32'h0, rd_val & 32'h4)
    `CHK("irq", 1'b0, irq)
    move(64, 1'b1, 20);
    `CHK("origin count", 16'h1, origin_count)
    `CHK("position", -8, position)
    // Origin pulses in both directions once a forward crossing after the restart arms the mark.
    settle();
    wr(8'h00, 32'ha);
    restart();
    `CHK("overspeed", 1'b0, overspeed_alarm)
    move(8, 1'b0, 3);
    move(8, 1'b1, 3);
    `CHK("origin count", 16'h3, origin_count)
    // Pulse count below its minimum stops the pulses once restarted.
    wr(8'h04, 32'h8);
    `CHK("setting error", 1'b0, setting_error_alarm)
    restart();
    `CHK("setting error", 1'b1, setting_error_alarm)
    pos_hold = position;
    move(8, 1'b0, -1);
    `CHK("position", pos_hold, position)
    // Linear at one edge per count with a limit of 16 counts per window.
    settle();
    wr(8'h04, 32'h10);
    wr(8'h08, 32'h10);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h9);
    wr(8'h1c, 32'h1);
    restart();
    `CHK("setting error", 1'b0, setting_error_alarm)
    move(4, 1'b0, -1);
    `CHK("position", pos_hold + 4, position)
    `CHK("overspeed", 1'b0, overspeed_alarm)
    move(40, 1'b0, -1);
    settle();
    `CHK("overspeed", 1'b1, overspeed_alarm)
    `CHK("irq", 1'b1, irq)
    `CHK("bad steps", 16'h0, bad_count)
    close_out();
  end
endmodule : tb
